// ### memory_partner.sv
// ****************************************************
// external memory on area 3, refresh side only
// ****************************************************
module memory_partner
(
  input wire logic ref_clk,
  input wire logic refresh_strobe_b,
  input wire logic slow,
  output logic wait_request,
  output int refresh_count
);
  timeunit 1ns;
  timeprecision 1ps;

  logic strobe_q = 1'b1;
  int wait_left = 2;

  // a slow part holds wait for the first two clocks of each refresh strobe only, so the
  // stretched cycle still ends; a prompt one never waits
  assign wait_request = slow & ~refresh_strobe_b & (wait_left > 0);

  // every chip refreshes off the shared strobe, so one count serves them all
  initial refresh_count = 0;
  always @(posedge ref_clk)
  begin
    if (strobe_q && !refresh_strobe_b)
    begin
      refresh_count <= refresh_count + 1;
    end
    if (refresh_strobe_b)
      wait_left <= 2;
    else if (wait_left > 0)
      wait_left <= wait_left - 1;
    strobe_q <= refresh_strobe_b;
  end
endmodule

// ### memory_refresh_interval_timer_tb_top.sv
module memory_refresh_interval_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************
  // stimulus, design and memory
  // ****************************************************
  logic ref_clk = 1'b0, rst_b = 1'b0, sleep_mode = 1'b0, hw_standby = 1'b0, sw_standby = 1'b0;
  logic dynamic_ram_enable = 1'b0, pseudo_static_enable = 1'b0, self_refresh_select = 1'b0;
  logic cas_mode = 1'b0, area3_access_states = 1'b0, ctrl_write_t3 = 1'b0, slow = 1'b0;
  logic irq_enable_wdata = 1'b0, flag_clear = 1'b0, counter_write_t3 = 1'b0;
  logic constant_write_t3 = 1'b0, ext_bus_req = 1'b0, dma_bus_req = 1'b0, cpu_bus_req = 1'b0;
  logic [2:0] clk_sel_wdata = 3'h0;
  logic [7:0] counter_wdata = 8'h00, constant_wdata = 8'h00, target = 8'h00;
  logic [1:0] bus_owner;
  logic [7:0] refresh_counter, refresh_constant;
  logic [2:0] clock_source_select;
  logic compare_match_flag, compare_irq_enable, compare_match_interrupt, refresh_busy;
  logic refresh_strobe_b, area3_chip_select_b, row_strobe_b, column_strobe_b, read_strobe_oe;
  logic upper_write_strobe_b, lower_write_strobe_b, write_strobe_oe, wait_request;
  int refresh_count, errors = 0, checks_done = 0, base, len;
  // rows: ext, dma, cpu request, then the owner they should give
  logic [4:0] rows [8] = '{5'b00011, 5'b00111, 5'b01010, 5'b01110,
                           5'b10000, 5'b10100, 5'b11000, 5'b11100};

  always #5 ref_clk = ~ref_clk;

  refresh_timer i_dut (.ref_clk, .rst_b, .sleep_mode, .hw_standby, .sw_standby,
    .dynamic_ram_enable, .pseudo_static_enable, .self_refresh_select, .cas_mode,
    .area3_access_states, .wait_request, .clk_sel_wdata, .ctrl_write_t3, .irq_enable_wdata,
    .flag_clear, .counter_wdata, .counter_write_t3, .constant_wdata, .constant_write_t3,
    .ext_bus_req, .dma_bus_req, .cpu_bus_req, .bus_owner, .refresh_counter, .refresh_constant,
    .clock_source_select, .compare_match_flag, .compare_irq_enable, .compare_match_interrupt,
    .refresh_busy, .refresh_strobe_b, .area3_chip_select_b, .row_strobe_b, .column_strobe_b,
    .read_strobe_oe, .upper_write_strobe_b, .lower_write_strobe_b, .write_strobe_oe);

  memory_partner i_mem (.ref_clk, .refresh_strobe_b, .slow, .wait_request, .refresh_count);

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic tally_and_finish();
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // kind 0 control, 1 counter, 2 constant, 3 flag clear; one cycle each
  task automatic write_reg(input int kind, input logic [7:0] v);
    @(posedge ref_clk);
    clk_sel_wdata <= v[2:0];
    irq_enable_wdata <= v[3];
    counter_wdata <= v;
    constant_wdata <= v;
    ctrl_write_t3 <= (kind == 0);
    counter_write_t3 <= (kind == 1);
    constant_write_t3 <= (kind == 2);
    flag_clear <= (kind == 3);
    @(posedge ref_clk);
    ctrl_write_t3 <= 1'b0;
    counter_write_t3 <= 1'b0;
    constant_write_t3 <= 1'b0;
    flag_clear <= 1'b0;
    #1;
  endtask

  function automatic logic hit(input int w);
    case (w)
      0: return compare_match_flag === 1'b1;
      1: return refresh_busy === 1'b1;
      default: return refresh_counter === target;
    endcase
  endfunction

  // bounded wait; running out ends the run as a failure
  task automatic wait_hit(input int w);
    int n;
    n = 0;
    while (!hit(w) && n < 1000)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 1000)
    begin
      errors++;
      $display("unexpected at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask

  task automatic busy_len(output int n);
    wait_hit(1);
    n = 0;
    while (refresh_busy === 1'b1 && n < 40)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 40)
    begin
      errors++;
      $display("unexpected at %0t: refresh cycle never ended", $time);
      tally_and_finish();
    end
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(refresh_counter === refresh_pkg::COUNTER_RST && refresh_constant === 8'hFF
      && clock_source_select === 3'h0 && compare_match_flag === 1'b0
      && compare_irq_enable === 1'b0 && refresh_strobe_b === 1'b1
      && read_strobe_oe === 1'b1, "reset state");
    // arbitration table, refresh idle
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      {ext_bus_req, dma_bus_req, cpu_bus_req} <= rows[i][4:2];
      @(posedge ref_clk);
      #1;
      chk(bus_owner === rows[i][1:0], "bus owner");
    end
    // interval timer, counting on through sleep
    @(posedge ref_clk);
    {ext_bus_req, dma_bus_req, cpu_bus_req} <= 3'h0;
    sleep_mode <= 1'b1;
    write_reg(2, 8'h03);
    write_reg(0, 8'h09);
    target = 8'h03;
    wait_hit(2);
    chk(compare_match_flag === 1'b0, "flag early at equality");
    wait_hit(0);
    chk(refresh_counter === 8'h00, "counter not cleared");
    chk(compare_match_interrupt === 1'b1 && refresh_busy === 1'b0, "timer irq");
    write_reg(0, 8'h01);
    chk(compare_match_interrupt === 1'b0, "irq not masked");
    // counter write on two edges in a row, one of them meets an increment
    @(posedge ref_clk);
    counter_wdata <= 8'h40;
    counter_write_t3 <= 1'b1;
    @(posedge ref_clk);
    counter_wdata <= 8'h50;
    #1;
    chk(refresh_counter === 8'h40, "write lost");
    @(posedge ref_clk);
    counter_write_t3 <= 1'b0;
    #1;
    chk(refresh_counter === 8'h50, "write lost");
    // constant written every cycle while the counter passes it
    write_reg(1, 8'h00);
    write_reg(3, 8'h00);
    @(posedge ref_clk);
    constant_wdata <= 8'h02;
    constant_write_t3 <= 1'b1;
    repeat (10) @(posedge ref_clk);
    constant_write_t3 <= 1'b0;
    #1;
    chk(refresh_counter > 8'h02 && compare_match_flag === 1'b0, "match not held off");
    // timer standby clears flag and enable, keeps select and constant
    write_reg(0, 8'h09);
    wait_hit(0);
    @(posedge ref_clk);
    sw_standby <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(compare_match_flag === 1'b0 && compare_irq_enable === 1'b0 && refresh_counter === 8'h00
      && clock_source_select === 3'h1 && refresh_constant === 8'h02, "timer standby");
    @(posedge ref_clk);
    sw_standby <= 1'b0;
    hw_standby <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(refresh_counter === 8'h00 && read_strobe_oe === 1'b0, "hardware standby");
    // dram refresh: first request skipped, later ones run
    @(posedge ref_clk);
    hw_standby <= 1'b0;
    dynamic_ram_enable <= 1'b1;
    dma_bus_req <= 1'b1;
    write_reg(2, 8'h01);
    write_reg(0, 8'h01);
    base = refresh_count;
    wait_hit(0);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(refresh_count == base && refresh_busy === 1'b0, "first request ran");
    wait_hit(1);
    chk(bus_owner === 2'h1, "refresh not above dma");
    busy_len(len);
    chk(len == 3 && refresh_count == base + 1, "refresh cycle");
    @(posedge ref_clk);
    slow <= 1'b1;
    area3_access_states <= 1'b1;
    busy_len(len);
    busy_len(len);
    chk(len == 5, "waits not inserted");
    // pseudo-static self-refresh standby
    @(posedge ref_clk);
    slow <= 1'b0;
    dynamic_ram_enable <= 1'b0;
    pseudo_static_enable <= 1'b1;
    self_refresh_select <= 1'b1;
    sw_standby <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(area3_chip_select_b === 1'b1 && refresh_strobe_b === 1'b0 && read_strobe_oe === 1'b0
      && write_strobe_oe === 1'b0, "psram self-refresh pins");
    chk(refresh_counter === 8'h00 && refresh_constant === 8'h01, "standby registers");
    @(posedge ref_clk);
    self_refresh_select <= 1'b0;
    #1;
    chk(refresh_strobe_b === 1'b1, "psram standby strobe");
    @(posedge ref_clk);
    self_refresh_select <= 1'b1;
    @(posedge ref_clk);
    sw_standby <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(refresh_strobe_b === 1'b1, "psram exit strobe");
    // dram self-refresh: column strobe first, then row strobe
    @(posedge ref_clk);
    pseudo_static_enable <= 1'b0;
    dynamic_ram_enable <= 1'b1;
    sw_standby <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(column_strobe_b === 1'b0 && row_strobe_b === 1'b1, "column strobe first");
    @(posedge ref_clk);
    #1;
    chk(column_strobe_b === 1'b0 && row_strobe_b === 1'b0, "row strobe second");
    @(posedge ref_clk);
    sw_standby <= 1'b0;
    #1;
    chk(column_strobe_b === 1'b1 && row_strobe_b === 1'b1, "self-refresh exit");
    tally_and_finish();
  end
endmodule

// ### refresh_clock_edge.sv
// ****************************************************
// counter clock from selected prescaler tap
// ****************************************************
module refresh_clock_edge #(
  parameter int PRESC_W = refresh_pkg::PRESC_W
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [2:0] clock_source_select,
  output logic count_pulse
);

  initial
  begin
    if (PRESC_W <= refresh_pkg::TAP_7)
      $error("prescaler too narrow for the highest tap");
  end

  logic [PRESC_W-1:0] presc_r;
  logic tap_now;
  logic tap_prev_r;

  // free-running prescaler, held clear when the block is stopped
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !run)
      presc_r <= '0;
    else
      presc_r <= presc_r + 1'b1;
  end

  // select 0 halts: the level reads as low
  always_comb
  begin
    case (clock_source_select)
      3'h1: tap_now = presc_r[refresh_pkg::TAP_1];
      3'h2: tap_now = presc_r[refresh_pkg::TAP_2];
      3'h3: tap_now = presc_r[refresh_pkg::TAP_3];
      3'h4: tap_now = presc_r[refresh_pkg::TAP_4];
      3'h5: tap_now = presc_r[refresh_pkg::TAP_5];
      3'h6: tap_now = presc_r[refresh_pkg::TAP_6];
      3'h7: tap_now = presc_r[refresh_pkg::TAP_7];
      default: tap_now = 1'b0;
    endcase
  end

  // previous level of whatever tap is selected, so a switch from a high
  // fast tap to a low slow tap looks like a falling edge by design
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !run)
      tap_prev_r <= 1'b0;
    else
      tap_prev_r <= tap_now;
  end

  assign count_pulse = run && tap_prev_r && !tap_now;

endmodule

// ### refresh_pkg.sv
package refresh_pkg;

  // ****************************************************
  // widths and reset values
  // ****************************************************
  localparam int CNT_W = 8;
  localparam logic [7:0] COUNTER_RST = 8'h00;
  localparam logic [7:0] CONSTANT_RST = 8'hFF;
  localparam logic [2:0] CLK_SEL_RST = 3'h0;
  // prescaler taps for clock select 1..7 (select 0 halts the counter)
  localparam int PRESC_W = 12;
  localparam int TAP_1 = 0;
  localparam int TAP_2 = 2;
  localparam int TAP_3 = 4;
  localparam int TAP_4 = 6;
  localparam int TAP_5 = 8;
  localparam int TAP_6 = 10;
  localparam int TAP_7 = 11;
  // refresh cycle length in clock cycles, same for both memory kinds
  localparam int REFRESH_CYCLES = 3;
  localparam logic [1:0] REFRESH_LAST = 2'h2;

  // bus owner after arbitration
  typedef enum logic [1:0]
  {
    OWN_EXT = 2'b00,
    OWN_REFRESH = 2'b01,
    OWN_DMA = 2'b10,
    OWN_CPU = 2'b11
  } bus_owner_t;

  // refresh sequencer states
  typedef enum logic [1:0]
  {
    RF_IDLE = 2'b00,
    RF_REQ = 2'b01,
    RF_CYCLE = 2'b10
  } refresh_state_t;

endpackage

// ### refresh_timer.sv
module refresh_timer #(
  parameter int CNT_W = refresh_pkg::CNT_W
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sleep_mode,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic dynamic_ram_enable,
  input wire logic pseudo_static_enable,
  input wire logic self_refresh_select,
  input wire logic cas_mode,
  input wire logic area3_access_states,
  input wire logic wait_request,
  input wire logic [2:0] clk_sel_wdata,
  input wire logic ctrl_write_t3,
  input wire logic irq_enable_wdata,
  input wire logic flag_clear,
  input wire logic [CNT_W-1:0] counter_wdata,
  input wire logic counter_write_t3,
  input wire logic [CNT_W-1:0] constant_wdata,
  input wire logic constant_write_t3,
  input wire logic ext_bus_req,
  input wire logic dma_bus_req,
  input wire logic cpu_bus_req,
  output logic [1:0] bus_owner,
  output logic [CNT_W-1:0] refresh_counter,
  output logic [CNT_W-1:0] refresh_constant,
  output logic [2:0] clock_source_select,
  output logic compare_match_flag,
  output logic compare_irq_enable,
  output logic compare_match_interrupt,
  output logic refresh_busy,
  output logic refresh_strobe_b,
  output logic area3_chip_select_b,
  output logic row_strobe_b,
  output logic column_strobe_b,
  output logic read_strobe_oe,
  output logic upper_write_strobe_b,
  output logic lower_write_strobe_b,
  output logic write_strobe_oe
);

  initial
  begin
    if (CNT_W < 2 || CNT_W > 16)
      $error("counter width out of range");
  end

  // ****************************************************
  // mode decode
  // ****************************************************
  logic run;
  logic mem_mode;
  logic timer_mode;
  logic standby_init;
  logic count_pulse;
  logic match_now;
  logic compare_evt;
  logic refresh_req;
  logic first_pending_r;
  logic [CNT_W-1:0] counter_r;
  logic [CNT_W-1:0] constant_r;
  logic [2:0] clk_sel_r;
  logic flag_r;
  logic irq_en_r;
  logic self_ref_active_r;
  logic cas_low_r;
  logic [1:0] cyc_cnt_r;
  refresh_pkg::refresh_state_t state_r;
  refresh_pkg::bus_owner_t owner;

  // sleep does not stop anything; only hardware standby and software standby do
  assign run = !hw_standby && !sw_standby;
  assign mem_mode = dynamic_ram_enable || pseudo_static_enable;
  assign timer_mode = !mem_mode;
  assign standby_init = sw_standby || hw_standby;

  refresh_clock_edge #(
    .PRESC_W(refresh_pkg::PRESC_W)
  ) u_edge (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(run),
    .clock_source_select(clk_sel_r),
    .count_pulse(count_pulse)
  );

  // ****************************************************
  // compare logic
  // ****************************************************
  // match is only signalled as the counter moves off the matching value
  assign match_now = (counter_r == constant_r);
  assign compare_evt = run && count_pulse && match_now && !constant_write_t3;

  // counter: clear beats write, write beats increment
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || standby_init)
      counter_r <= refresh_pkg::COUNTER_RST[CNT_W-1:0];
    else if (compare_evt)
      counter_r <= '0;
    else if (counter_write_t3)
      counter_r <= counter_wdata;
    else if (count_pulse)
      counter_r <= counter_r + 1'b1;
  end

  // constant survives software standby; hardware standby stops writes only
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      constant_r <= refresh_pkg::CONSTANT_RST[CNT_W-1:0];
    else if (constant_write_t3 && !hw_standby)
      constant_r <= constant_wdata;
  end

  // clock select is kept across standby
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      clk_sel_r <= refresh_pkg::CLK_SEL_RST;
    else if (ctrl_write_t3 && run)
      clk_sel_r <= clk_sel_wdata;
  end

  // flag: set wins over a software clear; standby clears it in timer use
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      flag_r <= 1'b0;
    else if (compare_evt)
      flag_r <= 1'b1;
    else if (standby_init && timer_mode)
      flag_r <= 1'b0;
    else if (flag_clear)
      flag_r <= 1'b0;
  end

  // interrupt enable cleared by standby only in timer use
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      irq_en_r <= 1'b0;
    else if (standby_init && timer_mode)
      irq_en_r <= 1'b0;
    else if (ctrl_write_t3 && run)
      irq_en_r <= irq_enable_wdata;
  end

  assign compare_match_interrupt = timer_mode && flag_r && irq_en_r;

  // ****************************************************
  // refresh request and cycle
  // ****************************************************
  // the first match after reset or standby is swallowed
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || standby_init)
      first_pending_r <= 1'b1;
    else if (compare_evt)
      first_pending_r <= 1'b0;
  end

  // same request path for DRAM and pseudo-static memory
  assign refresh_req = compare_evt && mem_mode && !first_pending_r;

  // fixed arbitration order
  always_comb
  begin
    if (ext_bus_req)
      owner = refresh_pkg::OWN_EXT;
    else if (state_r != refresh_pkg::RF_IDLE)
      owner = refresh_pkg::OWN_REFRESH;
    else if (dma_bus_req)
      owner = refresh_pkg::OWN_DMA;
    else
      owner = refresh_pkg::OWN_CPU;
  end
  assign bus_owner = owner;

  // a request held while the bus is elsewhere runs once after release;
  // a cycle already started runs on to its end, though an external master is still granted the bus at once
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || standby_init)
    begin
      state_r <= refresh_pkg::RF_IDLE;
      cyc_cnt_r <= 2'h0;
    end
    else
    begin
      case (state_r)
        refresh_pkg::RF_IDLE:
        begin
          if (refresh_req)
            state_r <= refresh_pkg::RF_REQ;
        end
        refresh_pkg::RF_REQ:
        begin
          if (!ext_bus_req)
          begin
            state_r <= refresh_pkg::RF_CYCLE;
            cyc_cnt_r <= 2'h0;
          end
        end
        refresh_pkg::RF_CYCLE:
        begin
          // wait states stretch the cycle only when enabled for area 3
          if (area3_access_states && wait_request)
            cyc_cnt_r <= cyc_cnt_r;
          else if (cyc_cnt_r == refresh_pkg::REFRESH_LAST)
            state_r <= refresh_pkg::RF_IDLE;
          else
            cyc_cnt_r <= cyc_cnt_r + 2'h1;
        end
        default:
          state_r <= refresh_pkg::RF_IDLE;
      endcase
    end
  end

  assign refresh_busy = (state_r == refresh_pkg::RF_CYCLE);

  // ****************************************************
  // self-refresh strobes
  // ****************************************************
  // column strobe goes low first, row strobe one cycle later
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || !sw_standby)
    begin
      cas_low_r <= 1'b0;
      self_ref_active_r <= 1'b0;
    end
    else
    begin
      cas_low_r <= self_refresh_select;
      self_ref_active_r <= cas_low_r;
    end
  end

  // pins: pseudo-static standby floats read and write strobes
  always_comb
  begin
    refresh_strobe_b = 1'b1;
    area3_chip_select_b = 1'b1;
    row_strobe_b = 1'b1;
    column_strobe_b = 1'b1;
    read_strobe_oe = 1'b1;
    write_strobe_oe = 1'b1;
    upper_write_strobe_b = 1'b1;
    lower_write_strobe_b = 1'b1;
    if (hw_standby)
    begin
      read_strobe_oe = 1'b0;
      write_strobe_oe = 1'b0;
    end
    else if (sw_standby && pseudo_static_enable && !dynamic_ram_enable)
    begin
      read_strobe_oe = 1'b0;
      write_strobe_oe = 1'b0;
      refresh_strobe_b = !self_refresh_select;
    end
    else if (sw_standby && dynamic_ram_enable)
    begin
      read_strobe_oe = self_refresh_select;
      write_strobe_oe = self_refresh_select;
      if (self_refresh_select)
      begin
        column_strobe_b = !cas_low_r;
        row_strobe_b = !self_ref_active_r;
        refresh_strobe_b = !cas_low_r;
        upper_write_strobe_b = !(cas_mode && cas_low_r);
        lower_write_strobe_b = !(cas_mode && cas_low_r);
      end
    end
    else if (refresh_busy)
    begin
      // every chip in area 3 sees this strobe at the same time
      refresh_strobe_b = 1'b0;
      column_strobe_b = 1'b0;
      row_strobe_b = (cyc_cnt_r == 2'h0);
    end
  end

  assign refresh_counter = counter_r;
  assign refresh_constant = constant_r;
  assign clock_source_select = clk_sel_r;
  assign compare_match_flag = flag_r;
  assign compare_irq_enable = irq_en_r;

  // ****************************************************
  // checks
  // ****************************************************
  compare_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    compare_evt && !standby_init |=> counter_r == '0)
    else $error("counter not cleared by compare match");

  flag_sets_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    compare_evt |=> flag_r)
    else $error("flag not set by compare match");

  match_needs_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(flag_r) |-> $past(count_pulse) && $past(match_now))
    else $error("flag set without leaving the match value");

  write_beats_inc_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    counter_write_t3 && !compare_evt && !standby_init |=> counter_r == $past(counter_wdata))
    else $error("counter write lost");

  constant_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    constant_write_t3 && !flag_r |=> !flag_r)
    else $error("compare not suppressed during constant write");

  first_swallowed_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    compare_evt && first_pending_r |=> state_r == refresh_pkg::RF_IDLE)
    else $error("first request produced a refresh");

  standby_init_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sw_standby |=> counter_r == '0 && $stable(constant_r) && $stable(clk_sel_r))
    else $error("standby did not keep settings");

  irq_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    compare_match_interrupt |-> irq_en_r && flag_r)
    else $error("interrupt while disabled");

  ext_first_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ext_bus_req |-> bus_owner == refresh_pkg::OWN_EXT)
    else $error("external master not granted");

  // standby legitimately cuts a cycle short, so it stops the check
  refresh_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b || standby_init)
    state_r == refresh_pkg::RF_REQ && !ext_bus_req && !standby_init |=> refresh_busy [*3])
    else $error("refresh cycle too short");

  cas_before_ras_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(row_strobe_b) && sw_standby |-> !$past(column_strobe_b))
    else $error("row strobe fell before column strobe");

endmodule
